// ### hw/sss_params.svh
// constants for the servo stop sequence selector
// Contract
// - three extra gear numerators, each 0 to 2^30, scale command pulses.
// - extra numerators apply only when pulses-per-rev is zero or full-closed.
// - positioning mode, numerator zero means encoder resolution is numerator.
// - full-closed mode, numerator zero forces numerator and denominator to one.
// - power-cycle settings, including divider and over-travel, apply after power-up.
// - setup 0 limits block their direction; setup 1 ignores both limits.
// - setup 2 raises run-inhibit error on either limit input.
// - over-travel sequence applies only with setup 0, governs decel and stop.
// - sequence 0 brakes, 1 zero torque; stopped zero torque, deviation held.
// - sequence 2 emergency stops, zero command, clears deviation around deceleration.
// - servo-off values 0 to 7 pick brake or free-run per phase.
// - values 0-3, 8, 9 clear deviation; 4-7 hold it.
// - values 8, 9 emergency stop energized, then brake or free-run.
// - emergency stop limits torque command to the emergency torque setting; a setting of 0 keeps the normal limit.
// - deceleration ends below 30 r/min; then motor counts as stopped.
// - held deviation during servo-off may raise excess deviation error.
// - error during servo-off uses alarm sequence; power loss uses power-loss sequence.
// - power-loss sequence 0 to 9 uses the servo-off encoding.
// - error while main power off applies alarm sequence.
// - power loss during servo-on with trip select 1 raises undervoltage, alarm.
// - trip select bit decides undervoltage once loss persists detection time.
// - detection time 70 to 2000 ms; 2000 disables detection.
// - trip select 0: power loss servo-offs without error, restores on return.
`ifndef SSS_PARAMS_SVH
`define SSS_PARAMS_SVH
`define SSS_ADDR_GEAR2      8'h00
`define SSS_ADDR_GEAR3      8'h04
`define SSS_ADDR_GEAR4      8'h08
`define SSS_ADDR_PDIV       8'h0C
`define SSS_ADDR_OT         8'h10
`define SSS_ADDR_SEQ        8'h14
`define SSS_ADDR_TRIP       8'h18
`define SSS_ADDR_ESTOP      8'h1C
`define SSS_ADDR_MISC       8'h20
`define SSS_ADDR_STATUS     8'h24
`define SSS_ADDR_GEAR_OUT   8'h28
`define SSS_ADDR_POWERUP    8'h2C
`define SSS_GEAR_MAX        31'h4000_0000
`define SSS_PDIV_MAX        19'h4_0000
`define SSS_OT_SETUP_RST    2'h1
`define SSS_OT_SEQ_RST      2'h0
`define SSS_SEQ_RST         4'h0
`define SSS_TRIP_RST        1'b1
`define SSS_DET_MS_RST      11'h046
`define SSS_DET_MS_MIN      11'h046
`define SSS_DET_MS_OFF      11'h7D0
`define SSS_STOP_RPM        16'h001E
`define SSS_CLK_MHZ         100
`define SSS_MS_CYCLES       (`SSS_CLK_MHZ * 1000)
`define SSS_RESP_OKAY       2'h0
`define SSS_RESP_SLVERR     2'h2
`endif

// ### hw/sss_pkg.sv
// types for the servo stop sequence selector
package sss_pkg;
  typedef enum logic [1:0] {ACT_RUN, ACT_BRAKE, ACT_FREE, ACT_ESTOP} sss_act_t;
  typedef enum {PH_RUN, PH_DECEL, PH_STOP} sss_phase_t;
  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } sss_axi_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } sss_axi_rsp_t;
  typedef struct packed {
    sss_act_t    decel;
    sss_act_t    stopped;
    logic        clear_dev;
  } sss_seq_t;
endpackage

// ### hw/sss_stop_select.sv
// servo stop sequence selector with axi4-lite settings
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "sss_params.svh"
module sss_stop_select #(
  parameter int DET_TICK = `SSS_MS_CYCLES,
  parameter int SPEED_W  = 16,
  parameter int TQ_W     = 10
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire sss_pkg::sss_axi_req_t axi_req_i,
  output sss_pkg::sss_axi_rsp_t     axi_rsp_o,
  input  wire logic                 servo_on_input_i,
  input  wire logic                 positive_limit_input_i,
  input  wire logic                 negative_limit_input_i,
  input  wire logic                 main_power_ok_i,
  input  wire logic                 alarm_i,
  input  wire logic                 full_closed_i,
  input  wire logic [19:0]          pulses_per_rev_setting_i,
  input  wire logic [30:0]          encoder_resolution_i,
  input  wire logic [SPEED_W-1:0]   motor_speed_i,
  input  wire logic                 excess_deviation_i,
  input  wire logic [TQ_W-1:0]      torque_limit_normal_i,
  output logic [30:0]               gear_num_o,
  output logic [30:0]               gear_den_o,
  output logic                      gear_override_o,
  output logic                      inhibit_pos_o,
  output logic                      inhibit_neg_o,
  output logic                      dynamic_brake_o,
  output logic                      free_run_o,
  output logic                      estop_o,
  output logic                      servo_enable_o,
  output logic                      clear_deviation_o,
  output logic [TQ_W-1:0]           torque_limit_o,
  output logic                      run_inhibit_error_o,
  output logic                      excess_deviation_error_o,
  output logic                      undervoltage_error_o,
  output logic                      alarm_seq_o,
  output logic [18:0]               pulse_out_denominator_o
);
  import sss_pkg::*;

  if (DET_TICK < 1 || SPEED_W < 5 || TQ_W < 1 || TQ_W > 16) begin
    $error("sss_stop_select: bad parameter");
  end

  typedef struct packed {
    logic [30:0] gear_numerator_two;
    logic [30:0] gear_numerator_three;
    logic [30:0] gear_numerator_four;
    logic [1:0]  gear_sel;
    logic [18:0] pulse_out_denominator;
    logic [1:0]  overtravel_setup;
    logic [1:0]  overtravel_stop_sequence;
    logic [3:0]  servo_off_sequence;
    logic [3:0]  power_loss_sequence;
    logic        undervoltage_trip_select;
    logic [10:0] power_off_detect_time;
    logic [TQ_W-1:0] estop_torque_limit;
    logic [18:0] act_pdiv;
    logic [1:0]  act_ot_setup;
    logic [1:0]  act_ot_seq;
    logic [10:0] act_det;
    logic        powerup_pend;
    logic [1:0]  pos_sync;
    logic [1:0]  neg_sync;
    logic [1:0]  son_sync;
    logic [1:0]  pwr_sync;
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic        bvalid;
    logic        bad_w;
    logic        rvalid;
    logic [31:0] rdata;
    logic        bad_r;
    sss_phase_t  phase;
    logic        ot_active;
    logic [31:0] tick;
    logic [10:0] ms_cnt;
    logic        pwr_lost;
    logic        uv_err;
    logic        ri_err;
    logic        ed_err;
    logic        alarm_seq;
    logic        db;
    logic        fr;
    logic        es;
    logic        srv_en;
    logic        clr;
    logic        inh_p;
    logic        inh_n;
    logic [TQ_W-1:0] tq;
    logic [30:0] num;
    logic [30:0] den;
    logic        ovr;
  } st_t;

  st_t q, d;

  function automatic sss_seq_t decode(input logic [3:0] v);
    sss_seq_t s;
    s.decel     = v[0] ? ACT_FREE : ACT_BRAKE;
    s.stopped   = v[1] ? ACT_FREE : ACT_BRAKE;
    s.clear_dev = 1'b1;
    // two low bits pick per phase
    if (v < 4'h8) begin
      s.clear_dev = ~v[2];
    end else begin
      s.decel   = ACT_ESTOP;
      s.stopped = v[0] ? ACT_FREE : ACT_BRAKE;
    end
    return s;
  endfunction

  logic        son_s, pos_s, neg_s, pwr_s, stop_slow, lim_hit;
  logic [31:0] rd_mux;
  logic        rd_ok;
  logic [30:0] sel_num;
  sss_seq_t    seq;

  always_comb begin
    son_s = q.son_sync[1];
    pos_s = q.pos_sync[1];
    neg_s = q.neg_sync[1];
    pwr_s = q.pwr_sync[1];
    // below 30 r/min counts as stopped
    stop_slow = (motor_speed_i < SPEED_W'(`SSS_STOP_RPM));
    lim_hit = pos_s | neg_s;
    rd_ok = 1'b1;
    unique case (axi_req_i.araddr[7:0])
      `SSS_ADDR_GEAR2:    rd_mux = {1'b0, q.gear_numerator_two};
      `SSS_ADDR_GEAR3:    rd_mux = {1'b0, q.gear_numerator_three};
      `SSS_ADDR_GEAR4:    rd_mux = {1'b0, q.gear_numerator_four};
      `SSS_ADDR_PDIV:     rd_mux = {13'h0, q.pulse_out_denominator};
      `SSS_ADDR_OT:       rd_mux = {28'h0, q.overtravel_stop_sequence, q.overtravel_setup};
      `SSS_ADDR_SEQ:      rd_mux = {24'h0, q.power_loss_sequence, q.servo_off_sequence};
      `SSS_ADDR_TRIP:     rd_mux = {20'h0, q.power_off_detect_time, q.undervoltage_trip_select};
      `SSS_ADDR_ESTOP:    rd_mux = 32'(q.estop_torque_limit);
      `SSS_ADDR_MISC:     rd_mux = {30'h0, q.gear_sel};
      `SSS_ADDR_STATUS:   rd_mux = {20'h0, q.alarm_seq, q.ed_err, q.ri_err, q.uv_err,
                                    q.pwr_lost, q.clr, q.srv_en, q.es, q.fr, q.db,
                                    2'(q.phase)};
      `SSS_ADDR_GEAR_OUT: rd_mux = {q.ovr, q.num};
      `SSS_ADDR_POWERUP:  rd_mux = {31'h0, q.powerup_pend};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_ok  = 1'b0;
      end
    endcase
    unique case (q.gear_sel)
      2'h1:    sel_num = q.gear_numerator_two;
      2'h2:    sel_num = q.gear_numerator_three;
      2'h3:    sel_num = q.gear_numerator_four;
      default: sel_num = 31'h0;
    endcase
  end

  always_comb begin
    d = q;
    d.son_sync = {q.son_sync[0], servo_on_input_i};
    d.pos_sync = {q.pos_sync[0], positive_limit_input_i};
    d.neg_sync = {q.neg_sync[0], negative_limit_input_i};
    d.pwr_sync = {q.pwr_sync[0], main_power_ok_i};
    // bus: address and data taken in either order
    if (axi_req_i.awvalid && !q.aw_got && !q.bvalid) begin
      d.aw_got  = 1'b1;
      d.aw_addr = axi_req_i.awaddr[7:0];
    end
    if (axi_req_i.wvalid && !q.w_got && !q.bvalid) begin
      d.w_got  = 1'b1;
      d.w_data = axi_req_i.wdata;
    end
    if (q.aw_got && q.w_got) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bad_w  = 1'b0;
      unique case (q.aw_addr)
        `SSS_ADDR_GEAR2: if (q.w_data <= {1'b0, `SSS_GEAR_MAX})
          d.gear_numerator_two = q.w_data[30:0]; else d.bad_w = 1'b1;
        `SSS_ADDR_GEAR3: if (q.w_data <= {1'b0, `SSS_GEAR_MAX})
          d.gear_numerator_three = q.w_data[30:0]; else d.bad_w = 1'b1;
        `SSS_ADDR_GEAR4: if (q.w_data <= {1'b0, `SSS_GEAR_MAX})
          d.gear_numerator_four = q.w_data[30:0]; else d.bad_w = 1'b1;
        `SSS_ADDR_PDIV: if (q.w_data <= {13'h0, `SSS_PDIV_MAX})
          d.pulse_out_denominator = q.w_data[18:0]; else d.bad_w = 1'b1;
        `SSS_ADDR_OT: if (q.w_data[1:0] != 2'h3 && q.w_data[3:2] != 2'h3) begin
          d.overtravel_setup         = q.w_data[1:0];
          d.overtravel_stop_sequence = q.w_data[3:2];
        end else d.bad_w = 1'b1;
        `SSS_ADDR_SEQ: if (q.w_data[3:0] <= 4'h9 && q.w_data[7:4] <= 4'h9) begin
          d.servo_off_sequence  = q.w_data[3:0];
          d.power_loss_sequence = q.w_data[7:4];
        end else d.bad_w = 1'b1;
        // detect time 70 to 2000 ms
        `SSS_ADDR_TRIP: if (q.w_data[11:1] >= `SSS_DET_MS_MIN
                            && q.w_data[11:1] <= `SSS_DET_MS_OFF) begin
          d.undervoltage_trip_select = q.w_data[0];
          d.power_off_detect_time    = q.w_data[11:1];
        end else d.bad_w = 1'b1;
        `SSS_ADDR_ESTOP: d.estop_torque_limit = q.w_data[TQ_W-1:0];
        `SSS_ADDR_MISC:  d.gear_sel = q.w_data[1:0];
        `SSS_ADDR_POWERUP: if (q.w_data[0]) begin
          d.act_pdiv   = q.pulse_out_denominator;
          d.act_ot_setup = q.overtravel_setup;
          d.act_ot_seq = q.overtravel_stop_sequence;
          d.act_det    = q.power_off_detect_time;
        end
        default: d.bad_w = 1'b1;
      endcase
    end
    if (q.bvalid && axi_req_i.bready) d.bvalid = 1'b0;
    if (axi_req_i.arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rdata  = rd_mux;
      d.bad_r  = ~rd_ok;
    end
    if (q.rvalid && axi_req_i.rready) d.rvalid = 1'b0;
    d.powerup_pend = (q.act_pdiv != q.pulse_out_denominator)
                   | (q.act_ot_setup != q.overtravel_setup)
                   | (q.act_ot_seq != q.overtravel_stop_sequence)
                   | (q.act_det != q.power_off_detect_time);

    // extra numerators only in these modes
    d.ovr = (q.gear_sel != 2'h0) && (full_closed_i || pulses_per_rev_setting_i == 20'h0);
    d.num = sel_num;
    d.den = 31'h1;
    if (sel_num == 31'h0) begin
      if (full_closed_i) begin
        d.num = 31'h1;
      end else begin
        d.num = encoder_resolution_i;
      end
    end

    // count ms while power stays lost
    d.tick = (q.tick >= 32'(DET_TICK - 1)) ? 32'h0 : q.tick + 32'h1;
    if (pwr_s) begin
      d.tick     = 32'h1;
      d.ms_cnt   = 11'h0;
      d.pwr_lost = 1'b0;
    end else if (q.act_det != `SSS_DET_MS_OFF && !q.pwr_lost && q.tick == 32'h0) begin
      if (q.ms_cnt + 11'h1 >= q.act_det) d.pwr_lost = 1'b1;
      else d.ms_cnt = q.ms_cnt + 11'h1;
    end
    // errors sticky until servo-on drops with alarm and both limit inputs clear; a fresh cause wins
    if (!son_s && !alarm_i && !lim_hit) begin
      d.uv_err = 1'b0;
      d.ri_err = 1'b0;
      d.ed_err = 1'b0;
    end
    // loss while servo-on, trip select 1
    if (d.pwr_lost && !q.pwr_lost && q.srv_en && q.undervoltage_trip_select) d.uv_err = 1'b1;
    if (q.act_ot_setup == 2'h2 && lim_hit) d.ri_err = 1'b1;
    if (excess_deviation_i && !q.clr) d.ed_err = 1'b1;
    d.alarm_seq = alarm_i | d.uv_err | d.ri_err | d.ed_err;

    // setup 0 blocks directions; setup 1 ignores
    d.inh_p = (q.act_ot_setup == 2'h0) && pos_s;
    d.inh_n = (q.act_ot_setup == 2'h0) && neg_s;
    d.ot_active = d.inh_p | d.inh_n;

    d.srv_en = son_s && !d.pwr_lost && !d.alarm_seq;
    if (d.srv_en) begin
      d.phase = PH_RUN;
    end else if (q.srv_en) begin
      d.phase = stop_slow ? PH_STOP : PH_DECEL;
    end else if (q.phase == PH_DECEL && stop_slow) begin
      d.phase = PH_STOP;
    end
    if (d.ot_active && d.srv_en) begin
      d.phase = stop_slow ? PH_STOP : PH_DECEL;
    end
    seq = decode(d.pwr_lost ? q.power_loss_sequence : q.servo_off_sequence);

    d.db  = 1'b0;
    d.fr  = 1'b0;
    d.es  = 1'b0;
    d.clr = 1'b0;
    if (d.alarm_seq) begin
      // alarm table is not encoded here; brake is the safe choice
      d.db  = 1'b1;
    end else if (d.ot_active && d.srv_en) begin
      // over-travel sequence only with setup 0
      unique case (q.act_ot_seq)
        2'h0: d.db = (d.phase == PH_DECEL);
        2'h1: d.db = 1'b0;
        default: begin
          d.es  = (d.phase == PH_DECEL);
          d.clr = 1'b1;
        end
      endcase
    end else if (!d.srv_en) begin
      unique case (d.phase == PH_DECEL ? seq.decel : seq.stopped)
        ACT_BRAKE: d.db = 1'b1;
        ACT_FREE:  d.fr = 1'b1;
        ACT_ESTOP: d.es = 1'b1;
        default:   d.db = 1'b0;
      endcase
      d.clr = seq.clear_dev;
    end
    d.tq = (d.es && q.estop_torque_limit != '0) ? q.estop_torque_limit : torque_limit_normal_i;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.overtravel_setup         <= `SSS_OT_SETUP_RST;
      q.act_ot_setup             <= `SSS_OT_SETUP_RST;
      q.overtravel_stop_sequence <= `SSS_OT_SEQ_RST;
      q.act_ot_seq               <= `SSS_OT_SEQ_RST;
      q.servo_off_sequence       <= `SSS_SEQ_RST;
      q.power_loss_sequence      <= `SSS_SEQ_RST;
      q.undervoltage_trip_select <= `SSS_TRIP_RST;
      q.power_off_detect_time    <= `SSS_DET_MS_RST;
      q.act_det                  <= `SSS_DET_MS_RST;
      q.phase                    <= PH_STOP;
      q.db                       <= 1'b1;
      q.den                      <= 31'h1;
    end else begin
      q <= d;
    end
  end

  always_comb begin
    axi_rsp_o.awready = !q.aw_got && !q.bvalid;
    axi_rsp_o.wready  = !q.w_got && !q.bvalid;
    axi_rsp_o.bvalid  = q.bvalid;
    axi_rsp_o.bresp   = q.bad_w ? `SSS_RESP_SLVERR : `SSS_RESP_OKAY;
    axi_rsp_o.arready = !q.rvalid;
    axi_rsp_o.rvalid  = q.rvalid;
    axi_rsp_o.rdata   = q.rdata;
    axi_rsp_o.rresp   = q.bad_r ? `SSS_RESP_SLVERR : `SSS_RESP_OKAY;
  end

  assign gear_num_o               = q.num;
  assign gear_den_o               = q.den;
  assign gear_override_o          = q.ovr;
  assign inhibit_pos_o            = q.inh_p;
  assign inhibit_neg_o            = q.inh_n;
  assign dynamic_brake_o          = q.db;
  assign free_run_o               = q.fr;
  assign estop_o                  = q.es;
  assign servo_enable_o           = q.srv_en | q.es;
  assign clear_deviation_o        = q.clr;
  assign torque_limit_o           = q.tq;
  assign run_inhibit_error_o      = q.ri_err;
  assign excess_deviation_error_o = q.ed_err;
  assign undervoltage_error_o     = q.uv_err;
  assign alarm_seq_o              = q.alarm_seq;
  assign pulse_out_denominator_o  = q.act_pdiv;
endmodule

// ### tb/sss_stop_select_assertions.sv
// concurrent checks on the stop selector ports
`timescale 1ns/1ps
module sss_stop_select_assertions #(
  parameter int DET_TICK = 100000
) (
  input wire logic                  clk_i,
  input wire logic                  rst_n_i,
  input wire sss_pkg::sss_axi_req_t axi_req_i,
  input wire sss_pkg::sss_axi_rsp_t axi_rsp_o,
  input wire logic                  servo_on_input_i,
  input wire logic                  positive_limit_input_i,
  input wire logic                  negative_limit_input_i,
  input wire logic                  main_power_ok_i,
  input wire logic                  excess_deviation_i,
  input wire logic [30:0]           gear_den_o,
  input wire logic                  inhibit_pos_o,
  input wire logic                  dynamic_brake_o,
  input wire logic                  free_run_o,
  input wire logic                  estop_o,
  input wire logic                  servo_enable_o,
  input wire logic                  run_inhibit_error_o,
  input wire logic                  excess_deviation_error_o,
  input wire logic                  undervoltage_error_o,
  input wire logic                  alarm_seq_o
);
  import sss_pkg::*;
  localparam int UV_MIN = 70 * DET_TICK;
  logic [3:0] pos_age_q;
  logic [3:0] lim_age_q;
  logic [3:0] on_age_q;
  logic [3:0] ex_age_q;
  int         low_cnt_q;
  // cycles since an input was last high, saturating
  function automatic logic [3:0] nxt(logic hit, logic [3:0] a, logic live);
    if (hit) return 4'h0;
    if (!live || a == 4'hF) return 4'hF;
    return a + 4'h1;
  endfunction
  always_ff @(posedge clk_i) begin
    pos_age_q <= nxt(positive_limit_input_i, pos_age_q, rst_n_i);
    lim_age_q <= nxt(positive_limit_input_i | negative_limit_input_i, lim_age_q, rst_n_i);
    on_age_q  <= nxt(servo_on_input_i, on_age_q, rst_n_i);
    ex_age_q  <= nxt(excess_deviation_i, ex_age_q, rst_n_i);
    low_cnt_q <= (main_power_ok_i || !rst_n_i) ? 0 : low_cnt_q + 1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_den_unity: assert property (
    gear_den_o == 31'h0000_0001) else $error("den not one");
  a_brake_excl: assert property (
    !(dynamic_brake_o && free_run_o)) else $error("brake and free-run");
  a_alarm_brake: assert property (
    alarm_seq_o |-> dynamic_brake_o && !free_run_o && !estop_o) else $error("alarm not braking");
  a_estop_live: assert property (
    estop_o |-> servo_enable_o) else $error("estop not energized");
  a_inhibit_cause: assert property (
    inhibit_pos_o |-> pos_age_q < 4'h6) else $error("inhibit uncaused");
  a_runinh_cause: assert property (
    $rose(run_inhibit_error_o) |-> lim_age_q < 4'h6) else $error("run inhibit uncaused");
  a_uv_wait: assert property (
    $rose(undervoltage_error_o) |-> low_cnt_q >= UV_MIN) else $error("uv too early");
  a_enable_cause: assert property (
    servo_enable_o && !estop_o |-> on_age_q < 4'h6) else $error("enable uncaused");
  a_excess_cause: assert property (
    $rose(excess_deviation_error_o) |-> ex_age_q < 4'h5) else $error("excess error uncaused");
  a_bresp_hold: assert property (
    axi_rsp_o.bvalid && !axi_req_i.bready |=> axi_rsp_o.bvalid && $stable(axi_rsp_o.bresp))
    else $error("bresp dropped");
  a_rdata_hold: assert property (
    axi_rsp_o.rvalid && !axi_req_i.rready |=> axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata))
    else $error("rdata dropped");
endmodule
bind sss_stop_select sss_stop_select_assertions #(.DET_TICK(DET_TICK)) chk_u (
  .clk_i, .rst_n_i, .axi_req_i, .axi_rsp_o, .servo_on_input_i, .positive_limit_input_i,
  .negative_limit_input_i, .main_power_ok_i, .excess_deviation_i, .gear_den_o,
  .inhibit_pos_o, .dynamic_brake_o, .free_run_o, .estop_o, .servo_enable_o,
  .run_inhibit_error_o, .excess_deviation_error_o, .undervoltage_error_o, .alarm_seq_o);

// ### tb/sss_motor_model.sv
// motor speed model driven by the selected stop action
`timescale 1ns/1ps
module sss_motor_model (
  input  wire logic  clk_i,
  input  wire logic  rst_n_i,
  input  wire logic  run_i,
  input  wire logic  stop_hard_i,
  input  wire logic  free_run_i,
  output logic [15:0] motor_speed_o
);
  // coasting sheds speed slower than braking, so phases stay visible
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) motor_speed_o <= 16'h0000;
    else if (stop_hard_i || free_run_i) begin
      if (motor_speed_o < 16'h0032) motor_speed_o <= 16'h0000;
      else motor_speed_o <= motor_speed_o - (stop_hard_i ? 16'h0032 : 16'h000A);
    end else if (run_i) motor_speed_o <= 16'h03E8;
  end
endmodule

// ### tb/sss_stop_select_tb.sv
// bench for the servo stop sequence selector
`timescale 1ns/1ps
`include "sss_params.svh"
module sss_stop_select_tb;
  import sss_pkg::*;
  localparam logic [1:0] OK = `SSS_RESP_OKAY;
  localparam logic [1:0] ER = `SSS_RESP_SLVERR;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  sss_axi_req_t req = '0;
  sss_axi_rsp_t rsp;
  logic son = 1'b0, plim = 1'b0, nlim = 1'b0, pwr = 1'b1, alm = 1'b0, fc = 1'b0, exd = 1'b0;
  logic run = 1'b0;
  logic [19:0] ppr = 20'h0_0000;
  logic [30:0] gnum, gden;
  logic [18:0] pdiv;
  logic [15:0] spd;
  logic [9:0]  tq;
  logic [3:0]  sv;
  logic gov, ipos, ineg, db, fr, es, sen, clr, rie, exe, uve, als;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  always #5 clk_i = ~clk_i;
  sss_stop_select #(.DET_TICK(10)) dut_u (.clk_i, .rst_n_i, .axi_req_i(req),
    .axi_rsp_o(rsp), .servo_on_input_i(son), .positive_limit_input_i(plim),
    .negative_limit_input_i(nlim), .main_power_ok_i(pwr), .alarm_i(alm), .full_closed_i(fc),
    .pulses_per_rev_setting_i(ppr), .encoder_resolution_i(31'h0002_0000), .motor_speed_i(spd),
    .excess_deviation_i(exd), .torque_limit_normal_i(10'h0FF), .gear_num_o(gnum),
    .gear_den_o(gden), .gear_override_o(gov), .inhibit_pos_o(ipos), .inhibit_neg_o(ineg),
    .dynamic_brake_o(db), .free_run_o(fr), .estop_o(es), .servo_enable_o(sen),
    .clear_deviation_o(clr), .torque_limit_o(tq), .run_inhibit_error_o(rie),
    .excess_deviation_error_o(exe), .undervoltage_error_o(uve), .alarm_seq_o(als),
    .pulse_out_denominator_o(pdiv));
  sss_motor_model mdl_u (.clk_i, .rst_n_i, .run_i(run),
    .stop_hard_i(db | es | ipos | ineg), .free_run_i(fr), .motor_speed_o(spd));
  task automatic summarize;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      $display("Error %0t: timeout", $time);
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
    @(posedge clk_i);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        req.bready <= 1'b0;
        chk(rsp.bresp, er, "write resp");
        break;
      end
    end
  endtask
  task automatic rd(input logic [31:0] a, exp, input logic [1:0] er);
    @(posedge clk_i);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) begin
        req.rready <= 1'b0;
        chk(rsp.rdata, exp, "read data");
        chk(rsp.rresp, er, "read resp");
        break;
      end
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wait_stop;
    while (spd >= 16'h001E) @(posedge clk_i);
    tick(5);
  endtask
  initial begin
    tick(3);
    rst_n_i <= 1'b1;
    chk(db, 1'b1, "reset brake");
    rd(`SSS_ADDR_OT, 32'h0000_0001, OK);
    rd(`SSS_ADDR_TRIP, 32'h0000_008D, OK);
    rd(32'h0000_0040, 32'h0000_0000, ER);
    wr(`SSS_ADDR_SEQ, 32'h0000_000A, ER);
    wr(`SSS_ADDR_GEAR2, 32'h4000_0001, ER);
    wr(`SSS_ADDR_TRIP, 32'h0000_008B, ER);
    wr(`SSS_ADDR_PDIV, 32'h0004_0001, ER);
    wr(`SSS_ADDR_PDIV, 32'h0004_0000, OK);
    chk(pdiv, 19'h0_0000, "div pending");
    $display("test refusals done");
    for (int g = 1; g < 4; g++) begin
      wr(32'(4 * (g - 1)), 32'(g + 5), OK);
      wr(`SSS_ADDR_MISC, 32'(g), OK);
      tick(3);
      chk(gnum, 32'(g + 5), "gear num");
    end
    wr(`SSS_ADDR_GEAR2, 32'h0000_0000, OK);
    wr(`SSS_ADDR_MISC, 32'h0000_0001, OK);
    tick(5);
    chk(gov, 1'b1, "override");
    chk(gnum, 31'h0002_0000, "enc num");
    fc <= 1'b1;
    tick(5);
    chk(gnum, 31'h0000_0001, "fc num");
    chk(gden, 31'h0000_0001, "fc den");
    fc <= 1'b0;
    ppr <= 20'h0_2710;
    tick(5);
    chk(gov, 1'b0, "no override");
    $display("test gear done");
    son <= 1'b1;
    run <= 1'b1;
    for (int s = 0; s < 3; s++) begin
      sv = s[3:0];
      plim <= 1'b0;
      wr(`SSS_ADDR_OT, {28'h000_0000, sv[1:0], 2'b00}, OK);
      if (s == 0) begin
        plim <= 1'b1;
        tick(6);
        chk(ipos, 1'b0, "ot pending");
        plim <= 1'b0;
      end
      wr(`SSS_ADDR_POWERUP, 32'h0000_0001, OK);
      tick(6);
      plim <= 1'b1;
      tick(5);
      chk(ipos, 1'b1, "pos inhibit");
      chk(ineg, 1'b0, "neg free");
      chk(db, sv == 4'h0, "ot decel brake");
      chk(es, sv == 4'h2, "ot decel estop");
      wait_stop();
      chk(db, 1'b0, "ot stop brake");
      chk(clr, sv == 4'h2, "ot dev");
    end
    plim <= 1'b0;
    chk(pdiv, 19'h4_0000, "div applied");
    wr(`SSS_ADDR_OT, 32'h0000_0002, OK);
    wr(`SSS_ADDR_POWERUP, 32'h0000_0001, OK);
    nlim <= 1'b1;
    tick(6);
    chk(rie, 1'b1, "run inhibit");
    nlim <= 1'b0;
    son <= 1'b0;
    tick(6);
    $display("test over-travel done");
    wr(`SSS_ADDR_ESTOP, 32'h0000_0005, OK);
    for (int v = 0; v < 10; v++) begin
      sv = v[3:0];
      wr(`SSS_ADDR_SEQ, 32'(v), OK);
      son <= 1'b1;
      tick(8);
      son <= 1'b0;
      tick(6);
      chk(db, sv < 8 && !sv[0], "decel brake");
      chk(fr, sv < 8 && sv[0], "decel free");
      chk(es, sv > 7, "decel estop");
      chk(sen, sv > 7, "energized");
      if (sv > 7) chk(tq, 32'h0000_0005, "estop torque");
      wait_stop();
      chk(db, sv < 8 ? !sv[1] : !sv[0], "stop brake");
      chk(fr, sv < 8 ? sv[1] : sv[0], "stop free");
      chk(clr, !(sv > 3 && sv < 8), "dev clear");
      if (v == 4) begin
        exd <= 1'b1;
        tick(4);
        chk(exe, 1'b1, "excess dev");
        chk(als, 1'b1, "error alarm");
        exd <= 1'b0;
        tick(4);
      end
    end
    $display("test servo-off done");
    wr(`SSS_ADDR_SEQ, 32'h0000_0030, OK);
    son <= 1'b1;
    tick(8);
    pwr <= 1'b0;
    tick(600);
    chk(uve, 1'b0, "uv early");
    tick(150);
    chk(uve, 1'b1, "uv trip");
    chk(als, 1'b1, "trip alarm");
    pwr <= 1'b1;
    son <= 1'b0;
    tick(8);
    wr(`SSS_ADDR_TRIP, 32'h0000_008C, OK);
    son <= 1'b1;
    tick(8);
    pwr <= 1'b0;
    tick(750);
    chk(uve, 1'b0, "no trip");
    chk(sen, 1'b0, "loss off");
    chk(fr, 1'b1, "loss sequence");
    pwr <= 1'b1;
    tick(8);
    chk(sen, 1'b1, "restored");
    wr(`SSS_ADDR_TRIP, 32'h0000_0FA1, OK);
    wr(`SSS_ADDR_POWERUP, 32'h0000_0001, OK);
    pwr <= 1'b0;
    tick(900);
    chk(uve, 1'b0, "no detect");
    son <= 1'b0;
    alm <= 1'b1;
    tick(6);
    chk(als, 1'b1, "alarm power off");
    chk(db, 1'b1, "alarm brake");
    $display("test power loss done");
    summarize();
  end
endmodule
